// ### verilog/pif_pkg.sv
// pif_pkg: register map, bit positions, reset values and carrier types
// for the peripheral interrupt flag block.
// assumes a 32-bit classic wishbone register bus with byte addressing.
package pif_pkg;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam int ADR_W = 8;
   localparam logic [7:0] OFF_FLAGS_ONE = 8'h00;
   localparam logic [7:0] OFF_FLAGS_TWO = 8'h04;
   localparam logic [7:0] OFF_ENABLE_ONE = 8'h08;
   localparam logic [7:0] OFF_ENABLE_TWO = 8'h0c;
   localparam logic [7:0] OFF_IRQ_CTRL = 8'h10;
   localparam logic [7:0] OFF_POWER_CTRL = 8'h14;
   localparam logic [7:0] OFF_RX_DATA = 8'h18;
   localparam logic [7:0] OFF_TX_DATA = 8'h1c;

   // ----------------------------------------------------------------
   // bit positions
   // ----------------------------------------------------------------
   localparam int B_NV_WRITE_DONE = 7;
   localparam int B_CONVERTER_DONE = 6;
   localparam int B_SERIAL_RX_FULL = 5;
   localparam int B_SERIAL_TX_EMPTY = 4;
   localparam int B_SYNC_SERIAL_DONE = 3;
   localparam int B_CAPCOMP_ONE = 2;
   localparam int B_PERIOD_MATCH = 1;
   localparam int B_TIMER_ONE_OVF = 0;

   localparam int B_OSC_FAILURE = 7;
   localparam int B_COMPARATOR_TWO = 6;
   localparam int B_COMPARATOR_ONE = 5;
   localparam int B_DISPLAY_MODULE = 4;
   localparam int B_LOW_VOLTAGE = 2;
   localparam int B_CAPCOMP_TWO = 0;

   localparam int B_GLOBAL_EN = 0;
   localparam int B_GROUP_EN = 1;

   localparam int B_SW_BROWNOUT_EN = 4;
   localparam int B_POR_STATUS = 1;
   localparam int B_BOR_STATUS = 0;

   // ----------------------------------------------------------------
   // masks and reset values
   // ----------------------------------------------------------------
   localparam logic [7:0] F1_SW_MASK = 8'hcf;
   localparam logic [7:0] F2_IMPL_MASK = 8'hf5;
   localparam logic [7:0] F2_SMALL_MASK = 8'hf4;
   localparam logic [7:0] FLAGS_RST = 8'h00;
   localparam logic [7:0] ENABLE_RST = 8'h00;
   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;

   // capture/compare unit mode
   localparam logic [1:0] CCP_CAPTURE = 2'h0;
   localparam logic [1:0] CCP_COMPARE = 2'h1;
   localparam logic [1:0] CCP_PWM = 2'h2;

   // ----------------------------------------------------------------
   // carrier types
   // ----------------------------------------------------------------
   typedef struct packed {
      logic cyc;
      logic stb;
      logic we;
      logic [ADR_W-1:0] adr;
      logic [3:0] sel;
      logic [31:0] dat;
   } pif_wb_req_type;

   typedef struct packed {
      logic nv_write_done;
      logic converter_done;
      logic rx_load;
      logic [7:0] rx_byte;
      logic tx_take;
      logic sync_serial_done;
      logic capcomp_one;
      logic [1:0] capcomp_one_mode;
      logic period_match;
      logic timer_one_overflow;
      logic osc_failure;
      logic comparator_two_output;
      logic comparator_one_output;
      logic display_module_irq;
      logic low_voltage_irq;
      logic capcomp_two;
      logic [1:0] capcomp_two_mode;
      logic brownout_reset;
   } pif_event_type;

   typedef struct packed {
      logic [7:0] flags_one;
      logic [7:0] flags_two;
      logic [7:0] enable_one;
      logic [7:0] enable_two;
      logic global_en;
      logic group_en;
      logic sw_brownout_enable;
      logic por_status;
      logic bor_status;
      logic [7:0] rx_buf;
      logic [7:0] tx_buf;
      logic tx_full;
      logic cmp_one_q;
      logic cmp_two_q;
      logic ack;
      logic [31:0] rdat;
      logic irq;
   } pif_state_type;

endpackage

// ### verilog/pif_top.sv
// pif_top: peripheral interrupt request flags, their enables, the
// serial data buffers that clear two flags, and the power control bits.
// assumes synchronous event inputs from the on-chip peripherals and a
// classic wishbone master on the register side.
//
// Operation
// - nv write done sets bit 7 of flags one; only a zero write clears it
// - converter done sets bit 6 of flags one; only a zero write clears it
// - rx full bit 5 is read-only, set while data held, cleared by rx read
// - tx empty bit 4 is read-only, set while buffer empty, cleared by tx write
// - sync serial done sets bit 3; software clears it
// - capture/compare one event sets bit 2 except in pwm mode; software clears
// - timer two period match sets bit 1; software clears it
// - timer one overflow sets bit 0; software clears it
// - flags set on events regardless of individual, group or global enables
// - oscillator failure sets bit 7 of flags two; software clears it
// - comparator two output change sets bit 6 of flags two; software clears
// - comparator one output change sets bit 5 of flags two; software clears
// - display module interrupt sets bit 4 of flags two
// - low voltage detector interrupt sets bit 2 of flags two
// - bits 3 and 1 of flags two always read zero
// - larger variants only: capture/compare two sets bit 0 except in pwm mode
// - power control holds power-on and brown-out reset status bits
// - power control holds a software brown-out enable
// - brown-out enable at bit 4, one enables, resets to one
//
// Decided for this implementation: register access over Wishbone and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module pif_top #(
   parameter bit HAS_CAPCOMP_TWO = 1'b1
) (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire pif_pkg::pif_wb_req_type wb_req_i,
   output logic wb_ack_o,
   output logic [31:0] wb_dat_o,
   input wire pif_pkg::pif_event_type evt_i,
   output logic [7:0] tx_byte_o,
   output logic tx_full_o,
   output logic brownout_enable_o,
   output logic periph_irq_o
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   pif_pkg::pif_state_type s_r;
   pif_pkg::pif_state_type s_nxt;

   logic access;
   logic wr_en;
   logic rd_en;
   logic [7:0] wbyte;
   logic [7:0] f2_mask;
   logic [7:0] ev_one;
   logic [7:0] ev_two;

   assign f2_mask = HAS_CAPCOMP_TWO ? pif_pkg::F2_IMPL_MASK : pif_pkg::F2_SMALL_MASK;
   // one access per request; the cycle in which ack is high is idle by design
   assign access = wb_req_i.cyc & wb_req_i.stb & ~s_r.ack;
   // registers are 8 bits wide, so only byte lane 0 matters for writes
   assign wr_en = access & wb_req_i.we & wb_req_i.sel[0];
   assign rd_en = access & ~wb_req_i.we;
   assign wbyte = wb_req_i.dat[7:0];

   // ----------------------------------------------------------------
   // event collection
   // ----------------------------------------------------------------
   always_comb begin
      ev_one = pif_pkg::BYTE_ZERO;
      ev_one[pif_pkg::B_NV_WRITE_DONE] = evt_i.nv_write_done;
      ev_one[pif_pkg::B_CONVERTER_DONE] = evt_i.converter_done;
      ev_one[pif_pkg::B_SYNC_SERIAL_DONE] = evt_i.sync_serial_done;
      ev_one[pif_pkg::B_CAPCOMP_ONE] = evt_i.capcomp_one &
         (evt_i.capcomp_one_mode != pif_pkg::CCP_PWM);
      ev_one[pif_pkg::B_PERIOD_MATCH] = evt_i.period_match;
      ev_one[pif_pkg::B_TIMER_ONE_OVF] = evt_i.timer_one_overflow;
      ev_two = pif_pkg::BYTE_ZERO;
      ev_two[pif_pkg::B_OSC_FAILURE] = evt_i.osc_failure;
      // change is seen against the value held one cycle earlier
      ev_two[pif_pkg::B_COMPARATOR_TWO] = evt_i.comparator_two_output ^ s_r.cmp_two_q;
      ev_two[pif_pkg::B_COMPARATOR_ONE] = evt_i.comparator_one_output ^ s_r.cmp_one_q;
      ev_two[pif_pkg::B_DISPLAY_MODULE] = evt_i.display_module_irq;
      ev_two[pif_pkg::B_LOW_VOLTAGE] = evt_i.low_voltage_irq;
      ev_two[pif_pkg::B_CAPCOMP_TWO] = HAS_CAPCOMP_TWO & evt_i.capcomp_two &
         (evt_i.capcomp_two_mode != pif_pkg::CCP_PWM);
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      s_nxt.ack = access;
      s_nxt.cmp_one_q = evt_i.comparator_one_output;
      s_nxt.cmp_two_q = evt_i.comparator_two_output;

      // software writes first, events afterwards so that a set wins
      if (wr_en && wb_req_i.adr == pif_pkg::OFF_FLAGS_ONE) begin
         s_nxt.flags_one = (s_r.flags_one & ~pif_pkg::F1_SW_MASK) |
            (wbyte & pif_pkg::F1_SW_MASK);
      end
      if (wr_en && wb_req_i.adr == pif_pkg::OFF_FLAGS_TWO) begin
         s_nxt.flags_two = wbyte & f2_mask;
      end
      // enables never gate flag setting, only the request output
      s_nxt.flags_one = s_nxt.flags_one | ev_one;
      s_nxt.flags_two = s_nxt.flags_two | ev_two;

      // receive buffer: a load in the same cycle as a read keeps the flag
      if (rd_en && wb_req_i.adr == pif_pkg::OFF_RX_DATA) begin
         s_nxt.flags_one[pif_pkg::B_SERIAL_RX_FULL] = 1'b0;
      end
      if (evt_i.rx_load) begin
         s_nxt.flags_one[pif_pkg::B_SERIAL_RX_FULL] = 1'b1;
         s_nxt.rx_buf = evt_i.rx_byte;
      end

      // transmit buffer: a take drains the old byte, a write then refills
      if (evt_i.tx_take) begin
         s_nxt.tx_full = 1'b0;
      end
      if (wr_en && wb_req_i.adr == pif_pkg::OFF_TX_DATA) begin
         s_nxt.tx_full = 1'b1;
         s_nxt.tx_buf = wbyte;
      end
      s_nxt.flags_one[pif_pkg::B_SERIAL_TX_EMPTY] = ~s_nxt.tx_full;

      if (wr_en && wb_req_i.adr == pif_pkg::OFF_ENABLE_ONE) begin
         s_nxt.enable_one = wbyte;
      end
      if (wr_en && wb_req_i.adr == pif_pkg::OFF_ENABLE_TWO) begin
         s_nxt.enable_two = wbyte & f2_mask;
      end
      if (wr_en && wb_req_i.adr == pif_pkg::OFF_IRQ_CTRL) begin
         s_nxt.global_en = wbyte[pif_pkg::B_GLOBAL_EN];
         s_nxt.group_en = wbyte[pif_pkg::B_GROUP_EN];
      end
      if (wr_en && wb_req_i.adr == pif_pkg::OFF_POWER_CTRL) begin
         s_nxt.sw_brownout_enable = wbyte[pif_pkg::B_SW_BROWNOUT_EN];
         s_nxt.por_status = wbyte[pif_pkg::B_POR_STATUS];
         s_nxt.bor_status = wbyte[pif_pkg::B_BOR_STATUS];
      end
      // a brown-out reset report beats a software write of the status bit
      if (evt_i.brownout_reset) begin
         s_nxt.bor_status = 1'b0;
      end

      // request output follows the flags already stored
      s_nxt.irq = s_r.global_en & s_r.group_en &
         (|(s_r.flags_one & s_r.enable_one) | |(s_r.flags_two & s_r.enable_two));

      // read data; unmapped offsets read as zero and ignore writes
      s_nxt.rdat = pif_pkg::WORD_ZERO;
      if (rd_en) begin
         unique case (wb_req_i.adr)
            pif_pkg::OFF_FLAGS_ONE: s_nxt.rdat[7:0] = s_r.flags_one;
            pif_pkg::OFF_FLAGS_TWO: s_nxt.rdat[7:0] = s_r.flags_two & f2_mask;
            pif_pkg::OFF_ENABLE_ONE: s_nxt.rdat[7:0] = s_r.enable_one;
            pif_pkg::OFF_ENABLE_TWO: s_nxt.rdat[7:0] = s_r.enable_two;
            pif_pkg::OFF_IRQ_CTRL: begin
               s_nxt.rdat[pif_pkg::B_GLOBAL_EN] = s_r.global_en;
               s_nxt.rdat[pif_pkg::B_GROUP_EN] = s_r.group_en;
            end
            pif_pkg::OFF_POWER_CTRL: begin
               s_nxt.rdat[pif_pkg::B_SW_BROWNOUT_EN] = s_r.sw_brownout_enable;
               s_nxt.rdat[pif_pkg::B_POR_STATUS] = s_r.por_status;
               s_nxt.rdat[pif_pkg::B_BOR_STATUS] = s_r.bor_status;
            end
            pif_pkg::OFF_RX_DATA: s_nxt.rdat[7:0] = s_r.rx_buf;
            pif_pkg::OFF_TX_DATA: s_nxt.rdat[7:0] = s_r.tx_buf;
            default: s_nxt.rdat = pif_pkg::WORD_ZERO;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= '0;
         s_r.flags_one <= pif_pkg::FLAGS_RST;
         s_r.flags_two <= pif_pkg::FLAGS_RST;
         s_r.enable_one <= pif_pkg::ENABLE_RST;
         s_r.enable_two <= pif_pkg::ENABLE_RST;
         s_r.sw_brownout_enable <= 1'b1;
         // power-on status reads zero until software sets it
         s_r.por_status <= 1'b0;
         s_r.bor_status <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_ack_o = s_r.ack;
   assign wb_dat_o = s_r.rdat;
   assign tx_byte_o = s_r.tx_buf;
   assign tx_full_o = s_r.tx_full;
   assign brownout_enable_o = s_r.sw_brownout_enable;
   assign periph_irq_o = s_r.irq;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   logic wr_f1_clr7;
   assign wr_f1_clr7 = wr_en && wb_req_i.adr == pif_pkg::OFF_FLAGS_ONE &&
      !wbyte[pif_pkg::B_NV_WRITE_DONE];

   AST_NV_SET: assert property (evt_i.nv_write_done |=> s_r.flags_one[7])
      else $error("nv write done flag not set");
   AST_NV_HOLD: assert property (s_r.flags_one[7] && !wr_f1_clr7 |=> s_r.flags_one[7])
      else $error("nv write done flag lost without a zero write");
   AST_CONV_SET: assert property (evt_i.converter_done && !s_r.enable_one[6]
      |=> s_r.flags_one[6])
      else $error("converter flag not set while disabled");
   AST_RX_CLEAR: assert property (rd_en && wb_req_i.adr == pif_pkg::OFF_RX_DATA
      && !evt_i.rx_load |=> !s_r.flags_one[5])
      else $error("rx full flag not cleared by data read");
   AST_TX_CLEAR: assert property (wr_en && wb_req_i.adr == pif_pkg::OFF_TX_DATA
      |=> !s_r.flags_one[4] && tx_full_o)
      else $error("tx empty flag not cleared by data write");
   AST_PWM_QUIET: assert property (!s_r.flags_one[2] && !wr_en
      && evt_i.capcomp_one_mode == pif_pkg::CCP_PWM |=> !s_r.flags_one[2])
      else $error("capture/compare flag set in pwm mode");
   AST_CMP_ONE: assert property ($changed(evt_i.comparator_one_output)
      && !$past(rst_i) |=> s_r.flags_two[5])
      else $error("comparator one change missed");
   AST_UNIMPL: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000
      && !(s_r.flags_two[3] || s_r.flags_two[1]))
      else $error("unimplemented bits nonzero");
   AST_RST_VAL: assert property ($past(rst_i) |-> s_r.sw_brownout_enable && s_r.flags_one == 8'h00
      && s_r.flags_two == 8'h00)
      else $error("reset values wrong");
   AST_IRQ: assert property (periph_irq_o |-> $past(s_r.global_en && s_r.group_en))
      else $error("irq raised without enables");
   AST_IRQ_RAISE: assert property (s_r.global_en && s_r.group_en && s_r.flags_one[0]
      && s_r.enable_one[0] |=> periph_irq_o)
      else $error("irq not raised for enabled flag");
   AST_ACK_ONE: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   AST_ACK_RESP: assert property (access |=> wb_ack_o)
      else $error("taken request not answered next cycle");
   AST_RDAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == pif_pkg::WORD_ZERO)
      else $error("read data nonzero outside ack");

   // ----------------------------------------------------------------
   // per-flag set and hold checks
   // ----------------------------------------------------------------
   // set checks ignore the enables on purpose: flags must never depend on
   // them; hold checks leave out only the write that is allowed to clear
   logic wr_f1;
   logic wr_f2;
   assign wr_f1 = wr_en && wb_req_i.adr == pif_pkg::OFF_FLAGS_ONE;
   assign wr_f2 = wr_en && wb_req_i.adr == pif_pkg::OFF_FLAGS_TWO;

   AST_CONV_HOLD: assert property (s_r.flags_one[6] && !wr_f1 |=> s_r.flags_one[6])
      else $error("converter flag lost without a write");
   AST_SSP_SET: assert property (evt_i.sync_serial_done |=> s_r.flags_one[3])
      else $error("sync serial flag not set");
   AST_SSP_HOLD: assert property (s_r.flags_one[3] && !wr_f1 |=> s_r.flags_one[3])
      else $error("sync serial flag lost without a write");
   AST_CAP_SET: assert property (evt_i.capcomp_one
      && evt_i.capcomp_one_mode != pif_pkg::CCP_PWM |=> s_r.flags_one[2])
      else $error("capture/compare one flag not set");
   AST_PER_SET: assert property (evt_i.period_match |=> s_r.flags_one[1])
      else $error("period match flag not set");
   AST_PER_HOLD: assert property (s_r.flags_one[1] && !wr_f1 |=> s_r.flags_one[1])
      else $error("period match flag lost without a write");
   AST_OVF_SET: assert property (evt_i.timer_one_overflow |=> s_r.flags_one[0])
      else $error("overflow flag not set");
   AST_OVF_HOLD: assert property (s_r.flags_one[0] && !wr_f1 |=> s_r.flags_one[0])
      else $error("overflow flag lost without a write");
   AST_EN_FREE: assert property (evt_i.timer_one_overflow && !s_r.global_en
      |=> s_r.flags_one[0])
      else $error("flag setting gated by enables");

   AST_RX_SET: assert property (evt_i.rx_load
      |=> s_r.flags_one[5] && s_r.rx_buf == $past(evt_i.rx_byte))
      else $error("rx load not captured");
   // the empty flag trails the buffer by one cycle only right after reset
   AST_TX_EMPTY: assert property (!$past(rst_i) |-> s_r.flags_one[4] == !tx_full_o)
      else $error("tx empty flag disagrees with buffer");

   AST_OSC_SET: assert property (evt_i.osc_failure |=> s_r.flags_two[7])
      else $error("oscillator failure flag not set");
   AST_OSC_HOLD: assert property (s_r.flags_two[7] && !wr_f2 |=> s_r.flags_two[7])
      else $error("oscillator failure flag lost without a write");
   AST_CMP_TWO: assert property ($changed(evt_i.comparator_two_output)
      && !$past(rst_i) |=> s_r.flags_two[6])
      else $error("comparator two change missed");
   AST_CMP_TWO_HOLD: assert property (s_r.flags_two[6] && !wr_f2 |=> s_r.flags_two[6])
      else $error("comparator two flag lost without a write");
   AST_DISP_SET: assert property (evt_i.display_module_irq |=> s_r.flags_two[4])
      else $error("display module flag not set");
   AST_DISP_HOLD: assert property (s_r.flags_two[4] && !wr_f2 |=> s_r.flags_two[4])
      else $error("display module flag lost without a write");
   AST_LV_SET: assert property (evt_i.low_voltage_irq |=> s_r.flags_two[2])
      else $error("low voltage flag not set");
   AST_LV_HOLD: assert property (s_r.flags_two[2] && !wr_f2 |=> s_r.flags_two[2])
      else $error("low voltage flag lost without a write");
   // on the smaller variant the bit must stay zero whatever happens
   AST_CCP2_SET: assert property (evt_i.capcomp_two
      && evt_i.capcomp_two_mode != pif_pkg::CCP_PWM
      |=> s_r.flags_two[0] == HAS_CAPCOMP_TWO)
      else $error("capture/compare two flag wrong");

   // ----------------------------------------------------------------
   // power control and request gating
   // ----------------------------------------------------------------
   AST_BO_WRITE: assert property (wr_en && wb_req_i.adr == pif_pkg::OFF_POWER_CTRL
      |=> brownout_enable_o == $past(wbyte[pif_pkg::B_SW_BROWNOUT_EN]))
      else $error("brown-out enable not written");
   AST_BOR_CLR: assert property (evt_i.brownout_reset |=> !s_r.bor_status)
      else $error("brown-out status not cleared by event");
   AST_IRQ_GLOBAL: assert property (!s_r.global_en |=> !periph_irq_o)
      else $error("irq raised with global enable off");
   AST_IRQ_GROUP: assert property (!s_r.group_en |=> !periph_irq_o)
      else $error("irq raised with group enable off");

   CVR_IRQ: cover property (periph_irq_o);
   CVR_RX_READ: cover property (s_r.flags_one[5] ##1 !s_r.flags_one[5]);
   CVR_CMP_TWO: cover property ($rose(s_r.flags_two[6]));
   CVR_SET_WINS: cover property (wr_f1_clr7 && evt_i.nv_write_done);
   CVR_TX_TAKE: cover property (evt_i.tx_take && s_r.tx_full);

endmodule

`default_nettype wire

// ### dv/pif_periph_model.sv
// pif_periph_model: stands in for the on-chip peripherals that raise events.
// assumes bench kicks change right after a rising edge of clk_i.
`timescale 1ns/1ps
`default_nettype none
module pif_periph_model (
   input wire logic clk_i,
   input wire logic [15:0] kick_i,
   input wire logic [1:0] mode_i,
   input wire logic [7:0] byte_i,
   output var pif_pkg::pif_event_type evt_o
);
   logic [15:0] k = 16'h0000;
   logic cmp_one = 1'b0;
   logic cmp_two = 1'b0;
   // ------------------------------------------------------------
   // kicks 13 and 14 toggle a comparator output, kick 11 drives nothing, the others become one-cycle events; index = flag bit (+8 for two), 9 = brown-out
   // ------------------------------------------------------------
   always @(posedge clk_i) begin
      k <= kick_i;
      if (kick_i[13]) cmp_one <= ~cmp_one;
      if (kick_i[14]) cmp_two <= ~cmp_two;
   end
   always_comb begin
      evt_o = '0;
      evt_o.timer_one_overflow = k[0];
      evt_o.period_match = k[1];
      evt_o.capcomp_one = k[2];
      evt_o.sync_serial_done = k[3];
      evt_o.tx_take = k[4];
      evt_o.rx_load = k[5];
      // byte is unqualified outside a load, so it is scrambled there
      evt_o.rx_byte = k[5] ? byte_i : ~byte_i;
      evt_o.converter_done = k[6];
      evt_o.nv_write_done = k[7];
      evt_o.capcomp_two = k[8];
      evt_o.brownout_reset = k[9];
      evt_o.low_voltage_irq = k[10];
      evt_o.display_module_irq = k[12];
      evt_o.comparator_one_output = cmp_one;
      evt_o.comparator_two_output = cmp_two;
      evt_o.osc_failure = k[15];
      evt_o.capcomp_one_mode = mode_i;
      evt_o.capcomp_two_mode = mode_i;
   end
endmodule
`default_nettype wire

// ### dv/pif_top_tb.sv
// pif_top_tb: self-checking bench for the peripheral flag block.
// assumes pif_periph_model drives the event inputs.
`timescale 1ns/1ps
`default_nettype none
module pif_top_tb;
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   pif_pkg::pif_wb_req_type req = '0;
   pif_pkg::pif_event_type evt;
   logic [15:0] kick = 16'h0000;
   logic [1:0] mode = pif_pkg::CCP_COMPARE;
   logic [7:0] rx_byte = 8'h00;
   logic wb_ack_o, tx_full_o, bo_en, irq;
   logic [31:0] wb_dat_o;
   logic [7:0] tx_byte_o, rd;
   int n_fail = 0;
   int tests_run = 0;

   pif_top pif_top_inst (.clk_i(clk_i), .rst_i(rst_i), .wb_req_i(req),
      .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .evt_i(evt), .tx_byte_o(tx_byte_o),
      .tx_full_o(tx_full_o), .brownout_enable_o(bo_en), .periph_irq_o(irq));
   pif_periph_model pif_periph_model_inst (.clk_i(clk_i), .kick_i(kick),
      .mode_i(mode), .byte_i(rx_byte), .evt_o(evt));

   initial forever #12.5 clk_i = ~clk_i;

   // ------------------------------------------------------------
   // shared tasks
   // ------------------------------------------------------------
   task automatic test_done();
      $display("checks %0d mismatches %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
      tests_run++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask
   // classic cycle: held until ack is sampled, then dropped for a cycle
   task automatic wb(input logic we, input logic [7:0] a, input logic [7:0] d);
      int n;
      n = 0;
      req <= '{cyc:1'b1, stb:1'b1, we:we, adr:a, sel:4'h1, dat:{24'h000000, d}};
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) begin
         n_fail++;
         test_done();
      end
      rd = wb_dat_o[7:0];
      req.cyc <= 1'b0;
      req.stb <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic kick_ev(input int i);
      kick <= 16'h0001 << i;
      @(posedge clk_i);
      kick <= 16'h0000;
      repeat (3) @(posedge clk_i);
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_reset();
      wb(0, 8'h00, 0); chk("flags_one", 8'h10, rd);
      wb(0, 8'h04, 0); chk("flags_two", 8'h00, rd);
      wb(0, 8'h14, 0); chk("power_ctrl", 8'h10, rd);
      chk("bo_en", 8'h01, {7'h00, bo_en});
   endtask
   task automatic t_sticky();
      int b[12] = '{0, 1, 2, 3, 6, 7, 8, 10, 12, 13, 14, 15};
      logic [7:0] a, e;
      foreach (b[i]) begin
         a = b[i] > 7 ? 8'h04 : 8'h00;
         e = b[i] > 7 ? 8'h00 : 8'h10;
         kick_ev(b[i]);
         wb(0, a, 0); chk("flag_set", e | (8'h01 << (b[i] % 8)), rd);
         wb(1, a, 0);
         wb(0, a, 0); chk("flag_clr", e, rd);
      end
   endtask
   task automatic t_capmode();
      mode <= pif_pkg::CCP_PWM;
      kick_ev(2);
      kick_ev(8);
      wb(0, 8'h00, 0); chk("pwm_one", 8'h10, rd);
      wb(0, 8'h04, 0); chk("pwm_two", 8'h00, rd);
      mode <= pif_pkg::CCP_CAPTURE;
      kick_ev(2);
      wb(0, 8'h00, 0); chk("capture_one", 8'h14, rd);
      wb(1, 8'h00, 0);
   endtask
   task automatic t_readonly();
      wb(1, 8'h00, 8'hff);
      wb(0, 8'h00, 0); chk("ro_one", 8'hdf, rd);
      wb(1, 8'h04, 8'hff);
      wb(0, 8'h04, 0); chk("ro_two", 8'hf5, rd);
      wb(1, 8'h00, 0);
      wb(1, 8'h04, 0);
   endtask
   task automatic t_serial();
      rx_byte <= 8'ha5;
      kick_ev(5);
      wb(0, 8'h00, 0); chk("rx_full", 8'h30, rd);
      wb(0, 8'h18, 0); chk("rx_data", 8'ha5, rd);
      wb(0, 8'h00, 0); chk("rx_read_clr", 8'h10, rd);
      wb(1, 8'h1c, 8'h3c);
      chk("tx_full", 8'h01, {7'h00, tx_full_o});
      chk("tx_byte", 8'h3c, tx_byte_o);
      wb(0, 8'h00, 0); chk("tx_busy", 8'h00, rd);
      kick_ev(4);
      wb(0, 8'h00, 0); chk("tx_empty", 8'h10, rd);
   endtask
   task automatic t_irq();
      wb(1, 8'h08, 8'h01);
      wb(1, 8'h10, 8'h01);
      kick_ev(0);
      @(posedge clk_i);
      chk("irq_no_group", 8'h00, {7'h00, irq});
      wb(1, 8'h10, 8'h03);
      repeat (2) @(posedge clk_i);
      chk("irq_on", 8'h01, {7'h00, irq});
      wb(1, 8'h00, 0);
      repeat (2) @(posedge clk_i);
      chk("irq_off", 8'h00, {7'h00, irq});
      wb(1, 8'h08, 0);
      wb(1, 8'h10, 0);
   endtask
   task automatic t_power();
      wb(1, 8'h14, 8'h00);
      chk("bo_off", 8'h00, {7'h00, bo_en});
      wb(0, 8'h14, 0); chk("power_rd", 8'h00, rd);
      wb(1, 8'h14, 8'h13);
      wb(0, 8'h14, 0); chk("power_status", 8'h13, rd);
      chk("bo_on", 8'h01, {7'h00, bo_en});
      wb(1, 8'h20, 8'hff);
      wb(0, 8'h20, 0); chk("unmapped", 8'h00, rd);
   endtask

   initial begin
      repeat (10) @(posedge clk_i);
      rst_i <= 1'b0;
      repeat (2) @(posedge clk_i);
      t_reset();
      t_sticky();
      t_capmode();
      t_readonly();
      t_serial();
      t_irq();
      t_power();
      test_done();
   end
endmodule
`default_nettype wire
